/* bench/nalu_core_tb.sv */
// Self-checking bench of the nibble ALU execution block
`timescale 1ns/1ps
module nalu_core_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    nalu_pkg::nalu_apb_req_type apb = '0;
    nalu_pkg::nalu_instr_type instr = '0;
    logic instr_valid = 1'b0;
    logic [31:0] port_pins = 32'h0000_0000;
    logic [31:0] prdata, port_out, rd;
    logic pready, pslverr, instr_ready, instr_done, carry_flag, int_reset, er;
    logic [9:0] rom_addr, rom_data;
    logic [3:0] acc_out;
    logic [3:0] a = 4'h0;
    logic c = 1'b0;
    logic [3:0] fams [4] = '{4'hf, 4'hd, 4'ha, 4'he};
    int num_errors = 0;
    int n_compared = 0;
    int zr = 0;

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (int_reset === 1'b1) zr++;
    end

    nalu_core DUT (.clk(clk), .nrst(nrst), .apb(apb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr(instr), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .instr_done(instr_done), .rom_addr(rom_addr),
        .rom_data(rom_data), .port_pins(port_pins), .port_out(port_out),
        .acc_out(acc_out), .carry_flag(carry_flag), .int_reset(int_reset));
    nalu_rom_model ROM (.clk(clk), .rom_addr(rom_addr), .rom_data(rom_data));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chka(input string what);
        chk({what, " acc"}, 32'(acc_out), 32'(a));
        chk({what, " carry"}, 32'(carry_flag), 32'(c));
    endtask

    function automatic logic [4:0] alu(input logic [3:0] f, input logic [3:0] x,
            input logic [3:0] b);
        case (f)
            4'hd: return {x[3] & b[3], x & b};
            4'he: return {1'b0, x | b};
            4'ha: return {x[3] & b[3], x ^ b};
            default: return {1'b0, b};
        endcase
    endfunction

    task automatic bus(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int n = 0;
        @(posedge clk);
        apb <= '{1'b1, 1'b0, wr, ad, wd};
        @(posedge clk);
        apb.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        apb <= '0;
        if (n >= 20) chk("bus timeout", 32'h0000_0000, 32'h0000_0001);
    endtask

    task automatic ex(input logic [9:0] w1, input logic [9:0] w2);
        int n = 0;
        @(posedge clk);
        instr <= '{w2, w1};
        instr_valid <= 1'b1;
        @(posedge clk);
        while (instr_ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        instr_valid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (instr_done !== 1'b1 && n < 40);
        #1;
        if (n >= 40) chk("instr timeout", 32'h0, 32'h1);
    endtask

    task automatic mv(input logic [3:0] x);
        ex({4'hf, 6'h31}, {6'h00, x});
        a = x;
        c = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_apb;
        bus(1'b0, 12'h00c, 32'h0000_0000);
        chk("unmapped err", 32'(er), 32'h0000_0001);
        chk("unmapped data", rd, 32'h0000_0000);
        bus(1'b1, nalu_pkg::ADDR_PORT_OUT, 32'hffff_ffff);
        bus(1'b0, nalu_pkg::ADDR_PORT_OUT, 32'h0000_0000);
        chk("port out ro", rd, 32'h0000_0000);
    endtask

    task automatic t_imm;
        for (int i = 0; i < 8; i++) begin
            ex({fams[i % 4], 6'h31}, {6'h00, (i < 4) ? 4'hb : 4'h6});
            {c, a} = alu(fams[i % 4], a, (i < 4) ? 4'hb : 4'h6);
            chka("imm op");
        end
    endtask

    task automatic t_reg;
        logic [3:0] sv;
        ex({4'h2, 2'b00, 4'h5}, {1'b0, 4'hc, 1'b0, 4'h9});
        for (int i = 0; i < 4; i++) begin
            ex({fams[i], ~i[0], 1'b0, 4'h5}, 10'h000);
            {c, a} = alu(fams[i], a, i[0] ? 4'h9 : 4'hc);
            chka("reg op");
        end
        mv(4'h9);
        ex(10'h393, 10'h000);
        a = 4'h3;
        c = 1'b1;
        chka("rotate");
        ex({4'h3, 2'b10, 4'h9}, 10'h000);
        chka("store");
        sv = a;
        mv(4'h5);
        ex({4'hf, 2'b10, 4'h9}, 10'h000);
        a = sv;
        chka("load stored");
    endtask

    task automatic t_rom;
        logic [9:0] w;
        bus(1'b1, nalu_pkg::ADDR_PAGE, 32'hffff_ffff);
        bus(1'b0, nalu_pkg::ADDR_PAGE, 32'h0000_0000);
        chk("page", rd, 32'h0000_0003);
        ex(10'h080, {1'b0, 4'h9, 1'b0, 4'he});
        // Pointer pair reaches the address one cycle after the write
        @(posedge clk);
        #1;
        chk("rom addr", 32'(rom_addr), 32'h0000_039e);
        w = 10'h39e ^ 10'h1c5;
        for (int j = 0; j < 8; j++) begin
            ex({fams[j % 4], j[2], 1'b1, 4'h0}, 10'h000);
            {c, a} = alu(fams[j % 4], a, j[2] ? w[3:0] : w[7:4]);
            chka("rom op");
        end
        ex({4'h2, 2'b10, 4'h7}, 10'h000);
        ex({4'hf, 2'b10, 4'h7}, 10'h000);
        {c, a} = {1'b0, w[7:4]};
        chka("pair high");
        ex({4'hf, 2'b00, 4'h7}, 10'h000);
        a = w[3:0];
        chka("pair low");
        ex({4'h2, 2'b10, 4'h0}, 10'h000);
        repeat (3) @(posedge clk);
        #1;
        chk("pointer kept", 32'(rom_addr), 32'h0000_039e);
    endtask

    task automatic t_unary;
        int z0;
        mv(4'hf);
        ex(10'h293, 10'h000);
        {c, a} = {1'b1, 4'h0};
        chka("inc wrap");
        ex(10'h293, 10'h000);
        {c, a} = {1'b0, 4'h1};
        chka("inc");
        z0 = zr;
        mv(4'h3);
        ex(10'h3d3, 10'h000);
        a = 4'h6;
        chka("rotate zero check");
        mv(4'h0);
        ex(10'h3d3, 10'h000);
        chka("zero rotate");
        @(posedge clk);
        #1;
        chk("internal reset", 32'(zr - z0), 32'h0000_0001);
        bus(1'b0, nalu_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status", 32'(rd[6:0]), 32'h0000_0040);
        bus(1'b1, nalu_pkg::ADDR_STATUS, 32'h0000_0040);
        bus(1'b0, nalu_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status cleared", 32'(rd[6:0]), 32'h0000_0000);
    endtask

    task automatic t_port;
        logic [31:0] po;
        logic [31:0] pv;
        logic [2:0] cd;
        po = 32'h0000_0000;
        pv = 32'h9c5a_36e1;
        @(posedge clk);
        port_pins <= pv;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            cd = (i % 4 < 2) ? 3'(i % 4) : 3'(i % 4 + 1);
            ex({fams[i % 4], i[2], 2'b11, cd}, 10'h000);
            {c, a} = alu(fams[i % 4], a, pv[4 * i +: 4]);
            chka("port op");
            ex({4'h2, i[2], 2'b11, cd}, 10'h000);
            po[4 * i +: 4] = a;
            chk("port out", port_out, po);
        end
        ex({4'h3, 3'b011, 3'h3}, {1'b0, 4'h7, 1'b0, 4'hd});
        po[27:24] = 4'h7;
        po[11:8] = 4'hd;
        chk("port pair", port_out, po);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #25000;
        chk("watchdog", 32'h0000_0000, 32'h0000_0001);
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chka("reset");
        chk("reset port out", port_out, 32'h0000_0000);
        t_apb();
        t_imm();
        t_reg();
        t_rom();
        t_unary();
        t_port();
        summarize();
    end
endmodule

/* bench/nalu_rom_model.sv */
// Program memory model answering the block's fetch address
`timescale 1ns/1ps
module nalu_rom_model #(
    parameter logic [9:0] FILL = 10'h1c5
) (
    input wire logic clk,
    input wire logic [9:0] rom_addr,
    output logic [9:0] rom_data
);
    // Synchronous read, word derived from its address
    always_ff @(posedge clk) begin
        rom_data <= rom_addr ^ FILL;
    end
endmodule

/* verilog/nalu_core.sv */
// Execution datapath of the 4-bit core: logic, rotate, port and transfer ops
//
// Overview of operation
// - AND with ROM nibble; carry from bit 3
// - ROM address from page and pointer pair
// - AND immediate; carry from both bit 3
// - OR register into accumulator, clear carry
// - OR ROM nibble into accumulator, clear carry
// - OR immediate into accumulator, clear carry
// - XOR register; carry from both bit 3
// - XOR ROM nibble; carry from bit 3
// - XOR immediate; carry from both bit 3
// - Increment accumulator; carry on wrap to zero
// - Rotate left; old bit 3 to carry
// - Zero accumulator rotate raises internal reset
// - Port input loads accumulator, clears carry
// - Port output latches accumulator until rewritten
// - Logic ops with port value
// - Immediate byte written to port pair
// - Register to accumulator, clear carry
// - ROM nibble to accumulator, clear carry
// - Immediate to accumulator, clear carry
// - Accumulator to register, carry unchanged
// - Immediate byte to register pair
// - ROM word to pair one to F
// - Page register gives two top address bits
// - AND register; carry from both bit 3
`timescale 1ns/1ps
module nalu_core (
    input wire logic clk,
    input wire logic nrst,
    input wire nalu_pkg::nalu_apb_req_type apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire nalu_pkg::nalu_instr_type instr,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic instr_done,
    output logic [9:0] rom_addr,
    input wire logic [9:0] rom_data,
    input wire logic [31:0] port_pins,
    output logic [31:0] port_out,
    output logic [3:0] acc_out,
    output logic carry_flag,
    output logic int_reset
);
    typedef struct packed {
        nalu_pkg::nalu_state_type st;
        nalu_pkg::nalu_instr_type ins;
        logic [3:0] acc;
        logic carry;
        logic [1:0] prog_page_select_reg;
        logic [31:0] pout;
        logic int_reset;
        logic zr_seen;
        logic [31:0] prdata;
        logic slverr;
    } nalu_core_state_type;
    localparam nalu_core_state_type CORE_RESET = '{
        st: nalu_pkg::ST_IDLE,
        acc: nalu_pkg::ACC_RESET,
        prog_page_select_reg: nalu_pkg::PAGE_RESET,
        pout: nalu_pkg::PORT_OUT_RESET,
        prdata: nalu_pkg::PRDATA_IDLE,
        default: '0
    };
    nalu_core_state_type s_q;
    nalu_core_state_type s_d;
    nalu_pkg::nalu_rf_wr_type rf_wr;
    nalu_pkg::nalu_op_type op;
    logic [7:0] rf_rd;
    logic [7:0] rom_pointer_pair;
    logic [31:0] pins_s;
    logic [3:0] fam;
    logic bank;
    logic [3:0] idx;
    logic [3:0] pslot;
    logic [3:0] opnd;
    logic [4:0] alu;
    logic [7:0] imm8;
    logic ex;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic nalu_pkg::nalu_op_type decode(input logic [9:0] w);
        logic [3:0] f;
        logic [3:0] lo;
        logic lfam;
        f = w[nalu_pkg::FAM_MSB:nalu_pkg::FAM_LSB];
        lo = w[3:0];
        lfam = (f == nalu_pkg::FAM_AND) || (f == nalu_pkg::FAM_OR)
            || (f == nalu_pkg::FAM_XOR) || (f == nalu_pkg::FAM_LOAD);
        decode = nalu_pkg::OP_NOP;
        if (!w[nalu_pkg::KIND_BIT]) begin
            if (lfam) begin
                decode = nalu_pkg::OP_REG;
            end else if (f == nalu_pkg::FAM_STORE) begin
                decode = nalu_pkg::OP_STORE;
            end else if (f == nalu_pkg::FAM_OUT && !w[nalu_pkg::BANK_BIT]) begin
                decode = nalu_pkg::OP_PAIR_IMM;
            end else if (f == nalu_pkg::FAM_OUT && lo != nalu_pkg::POINTER_PAIR) begin
                decode = nalu_pkg::OP_PAIR_ROM;
            end
        end else if (w[nalu_pkg::PORT_BIT]) begin
            if (lfam) begin
                decode = nalu_pkg::OP_PORT;
            end else if (f == nalu_pkg::FAM_OUT) begin
                decode = nalu_pkg::OP_OUT_A;
            end else if (f == nalu_pkg::FAM_STORE && !w[nalu_pkg::BANK_BIT]) begin
                decode = nalu_pkg::OP_OUT_IMM;
            end
        end else if (lo == nalu_pkg::LO_ROM && lfam) begin
            decode = nalu_pkg::OP_ROM;
        end else if (lo == nalu_pkg::LO_IMM && w[nalu_pkg::BANK_BIT] && lfam) begin
            decode = nalu_pkg::OP_IMM;
        end else if (lo == nalu_pkg::LO_UNARY && !w[nalu_pkg::BANK_BIT]) begin
            if (f == nalu_pkg::FAM_XOR) begin
                decode = nalu_pkg::OP_INC;
            end else if (f == nalu_pkg::FAM_OR) begin
                decode = nalu_pkg::OP_ROT;
            end else if (f == nalu_pkg::FAM_LOAD) begin
                decode = nalu_pkg::OP_ROTZ;
            end
        end
    endfunction
    // Valid flag and 3-bit latch slot {bank, index code}
    function automatic logic [3:0] port_slot(input logic b, input logic [2:0] code);
        port_slot = {1'b1, b, 2'h0};
        case (code)
            3'h0: port_slot[1:0] = 2'h0;
            3'h1: port_slot[1:0] = 2'h1;
            3'h3: port_slot[1:0] = 2'h2;
            3'h4: port_slot[1:0] = 2'h3;
            default: port_slot[3] = 1'b0;
        endcase
    endfunction
    function automatic logic [3:0] nib(input logic [31:0] v, input logic [2:0] slot);
        nib = v[{slot, 2'h0} +: 4];
    endfunction
    // Carry in bit 4, result in bits 3..0
    function automatic logic [4:0] alu_fn(input logic [3:0] f, input logic [3:0] a,
                                          input logic [3:0] b);
        case (f)
            nalu_pkg::FAM_AND: alu_fn = {a[3] & b[3], a & b};
            nalu_pkg::FAM_OR: alu_fn = {1'b0, a | b};
            nalu_pkg::FAM_XOR: alu_fn = {a[3] & b[3], a ^ b};
            default: alu_fn = {1'b0, b};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Submodules
    nalu_regfile u_regfile (
        .clk(clk),
        .nrst(nrst),
        .rd_addr(idx),
        .wr(rf_wr),
        .rd_data(rf_rd),
        .ptr_data(rom_pointer_pair)
    );
    nalu_pin_sync u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .pins(port_pins),
        .level(pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Operand path
    assign fam = s_q.ins.word1[nalu_pkg::FAM_MSB:nalu_pkg::FAM_LSB];
    assign bank = s_q.ins.word1[nalu_pkg::BANK_BIT];
    assign idx = s_q.ins.word1[3:0];
    assign pslot = port_slot(bank, s_q.ins.word1[2:0]);
    assign imm8 = {s_q.ins.word2[nalu_pkg::IMM_HI_MSB:nalu_pkg::IMM_HI_LSB], s_q.ins.word2[3:0]};
    assign op = decode(s_q.ins.word1);
    assign ex = (s_q.st == nalu_pkg::ST_EX);
    always_comb begin
        case (op)
            nalu_pkg::OP_REG: opnd = bank ? rf_rd[7:4] : rf_rd[3:0];
            nalu_pkg::OP_ROM: opnd = bank ? rom_data[3:0] : rom_data[7:4];
            nalu_pkg::OP_IMM: opnd = s_q.ins.word2[3:0];
            nalu_pkg::OP_PORT: opnd = nib(pins_s, pslot[2:0]);
            default: opnd = 4'h0;
        endcase
    end
    assign alu = alu_fn(fam, s_q.acc, opnd);

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        rf_wr = '0;
        s_d.int_reset = 1'b0;
        // Register access; setup phase prepares read data
        if (apb.psel && !apb.penable) begin
            s_d.prdata = nalu_pkg::PRDATA_IDLE;
            s_d.slverr = 1'b0;
            if (apb.paddr == nalu_pkg::ADDR_PAGE) begin
                s_d.prdata[1:0] = s_q.prog_page_select_reg;
            end else if (apb.paddr == nalu_pkg::ADDR_STATUS) begin
                s_d.prdata[nalu_pkg::STAT_ACC_LSB +: 4] = s_q.acc;
                s_d.prdata[nalu_pkg::STAT_CARRY_BIT] = s_q.carry;
                s_d.prdata[nalu_pkg::STAT_BUSY_BIT] = (s_q.st != nalu_pkg::ST_IDLE);
                s_d.prdata[nalu_pkg::STAT_ZRESET_BIT] = s_q.zr_seen;
            end else if (apb.paddr == nalu_pkg::ADDR_PORT_OUT) begin
                s_d.prdata = s_q.pout;
            end else begin
                s_d.slverr = 1'b1;
            end
        end
        if (apb.psel && apb.penable && apb.pwrite) begin
            if (apb.paddr == nalu_pkg::ADDR_PAGE) begin
                s_d.prog_page_select_reg = apb.pwdata[1:0];
            end else if (apb.paddr == nalu_pkg::ADDR_STATUS
                         && apb.pwdata[nalu_pkg::STAT_ZRESET_BIT]) begin
                s_d.zr_seen = 1'b0;
            end
        end
        // Execution sequence
        case (s_q.st)
            nalu_pkg::ST_IDLE: begin
                if (instr_valid) begin
                    s_d.ins = instr;
                    s_d.st = nalu_pkg::ST_RD;
                end
            end
            nalu_pkg::ST_RD: s_d.st = nalu_pkg::ST_RM;
            nalu_pkg::ST_RM: s_d.st = nalu_pkg::ST_EX;
            nalu_pkg::ST_EX: begin
                s_d.st = nalu_pkg::ST_IDLE;
                case (op)
                    nalu_pkg::OP_REG, nalu_pkg::OP_ROM, nalu_pkg::OP_IMM: begin
                        s_d.acc = alu[3:0];
                        s_d.carry = alu[4];
                    end
                    nalu_pkg::OP_PORT: begin
                        if (pslot[3]) begin
                            s_d.acc = alu[3:0];
                            s_d.carry = alu[4];
                        end
                    end
                    nalu_pkg::OP_INC: begin
                        s_d.acc = 4'(s_q.acc + 4'h1);
                        s_d.carry = (s_q.acc == 4'hf);
                    end
                    nalu_pkg::OP_ROT: begin
                        s_d.acc = {s_q.acc[2:0], s_q.acc[3]};
                        s_d.carry = s_q.acc[3];
                    end
                    nalu_pkg::OP_ROTZ: begin
                        if (s_q.acc == 4'h0) begin
                            s_d.int_reset = 1'b1;
                            s_d.zr_seen = 1'b1;
                        end else begin
                            s_d.acc = {s_q.acc[2:0], s_q.acc[3]};
                            s_d.carry = s_q.acc[3];
                        end
                    end
                    nalu_pkg::OP_OUT_A: begin
                        if (pslot[3]) begin
                            s_d.pout[{pslot[2:0], 2'h0} +: 4] = s_q.acc;
                        end
                    end
                    nalu_pkg::OP_OUT_IMM: begin
                        if (pslot[3]) begin
                            s_d.pout[{1'b1, pslot[1:0], 2'h0} +: 4] = imm8[7:4];
                            s_d.pout[{1'b0, pslot[1:0], 2'h0} +: 4] = imm8[3:0];
                        end
                    end
                    nalu_pkg::OP_STORE: begin
                        rf_wr.en = bank ? 2'b10 : 2'b01;
                        rf_wr.addr = idx;
                        rf_wr.data = {s_q.acc, s_q.acc};
                    end
                    nalu_pkg::OP_PAIR_IMM: begin
                        rf_wr.en = 2'b11;
                        rf_wr.addr = idx;
                        rf_wr.data = imm8;
                    end
                    nalu_pkg::OP_PAIR_ROM: begin
                        rf_wr.en = 2'b11;
                        rf_wr.addr = idx;
                        rf_wr.data = rom_data[7:0];
                    end
                    default: s_d.st = nalu_pkg::ST_IDLE;
                endcase
            end
            default: s_d.st = nalu_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= CORE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rom_addr = {s_q.prog_page_select_reg, rom_pointer_pair};
    assign prdata = s_q.prdata;
    assign pready = 1'b1;
    assign pslverr = s_q.slverr & apb.psel & apb.penable;
    assign instr_ready = (s_q.st == nalu_pkg::ST_IDLE);
    assign instr_done = ex;
    assign port_out = s_q.pout;
    assign acc_out = s_q.acc;
    assign carry_flag = s_q.carry;
    assign int_reset = s_q.int_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    chk_and_rom_high: assert property (
        ex && op == nalu_pkg::OP_ROM && fam == nalu_pkg::FAM_AND && !bank
        |=> s_q.acc == ($past(s_q.acc) & $past(rom_data[7:4]))
            && s_q.carry == ($past(s_q.acc[3]) & $past(rom_data[7]))
    ) else $error("AND with ROM high nibble wrong");
    chk_rom_pointer: assert property (
        ex && op == nalu_pkg::OP_PAIR_IMM && idx == nalu_pkg::POINTER_PAIR
        |-> ##2 rom_addr[7:0] == $past(imm8, 2)
    ) else $error("ROM address low byte not from pointer pair");
    chk_page_bits: assert property (
        apb.psel && apb.penable && apb.pwrite && apb.paddr == nalu_pkg::ADDR_PAGE
        |=> rom_addr[9:8] == $past(apb.pwdata[1:0])
    ) else $error("Page write not on ROM address top bits");
    chk_or_clear: assert property (
        ex && fam == nalu_pkg::FAM_OR
        && (op == nalu_pkg::OP_REG || op == nalu_pkg::OP_ROM || op == nalu_pkg::OP_IMM)
        |=> !s_q.carry
    ) else $error("OR left carry set");
    chk_xor_imm: assert property (
        ex && op == nalu_pkg::OP_IMM && fam == nalu_pkg::FAM_XOR
        |=> s_q.acc == ($past(s_q.acc) ^ $past(s_q.ins.word2[3:0]))
            && s_q.carry == ($past(s_q.acc[3]) & $past(s_q.ins.word2[3]))
    ) else $error("XOR immediate wrong");
    chk_inc_wrap: assert property (
        ex && op == nalu_pkg::OP_INC
        |=> s_q.carry == (s_q.acc == 4'h0) && s_q.acc == 4'($past(s_q.acc) + 4'h1)
    ) else $error("Increment or wrap carry wrong");
    chk_rotate_left: assert property (
        ex && op == nalu_pkg::OP_ROT
        |=> s_q.acc[3:1] == $past(s_q.acc[2:0]) && s_q.acc[0] == $past(s_q.acc[3])
            && s_q.carry == $past(s_q.acc[3])
    ) else $error("Rotate left wrong");
    chk_zero_reset: assert property (
        ex && op == nalu_pkg::OP_ROTZ && s_q.acc == 4'h0
        |=> int_reset && s_q.acc == 4'h0 ##1 !int_reset
    ) else $error("Zero rotate did not pulse internal reset");
    chk_reset_cause: assert property (
        int_reset |-> $past(ex) && $past(op) == nalu_pkg::OP_ROTZ
    ) else $error("Internal reset without zero rotate");
    chk_port_pair: assert property (
        ex && op == nalu_pkg::OP_OUT_IMM && pslot[3]
        |=> nib(port_out, {1'b1, $past(pslot[1:0])}) == $past(imm8[7:4])
            && nib(port_out, {1'b0, $past(pslot[1:0])}) == $past(imm8[3:0])
    ) else $error("Port pair immediate not latched");
    chk_store_carry: assert property (
        ex && op == nalu_pkg::OP_STORE |=> $stable(s_q.carry) && $stable(s_q.acc)
    ) else $error("Register store changed accumulator or carry");
    chk_instr_slots: assert property (
        instr_valid && instr_ready |=> !instr_ready [*3] ##1 instr_ready
    ) else $error("Instruction occupancy not four cycles");
endmodule

/* verilog/nalu_pin_sync.sv */
// Three-stage synchroniser for the port input pins
`timescale 1ns/1ps
module nalu_pin_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [nalu_pkg::PORT_BITS-1:0] pins,
    output logic [nalu_pkg::PORT_BITS-1:0] level
);
    typedef struct packed {
        logic [nalu_pkg::PORT_BITS-1:0] ff1;
        logic [nalu_pkg::PORT_BITS-1:0] ff2;
        logic [nalu_pkg::PORT_BITS-1:0] ff3;
        logic [nalu_pkg::PORT_BITS-1:0] out;
    } nalu_sync_state_type;

    nalu_sync_state_type s_q;
    nalu_sync_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.ff1 = pins;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        for (int i = 0; i < nalu_pkg::PORT_BITS; i++) begin
            if (s_q.ff2[i] == s_q.ff3[i]) begin
                s_d.out[i] = s_q.ff3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.out;
endmodule

/* verilog/nalu_pkg.sv */
// Shared constants and types of the nibble ALU execution block
package nalu_pkg;
    localparam int PORT_BITS = 32;
    localparam logic [11:0] ADDR_PAGE = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_PORT_OUT = 12'h008;
    localparam int STAT_ACC_LSB = 0;
    localparam int STAT_CARRY_BIT = 4;
    localparam int STAT_BUSY_BIT = 5;
    localparam int STAT_ZRESET_BIT = 6;
    localparam logic [1:0] PAGE_RESET = 2'h0;
    localparam logic [3:0] ACC_RESET = 4'h0;
    localparam logic [31:0] PORT_OUT_RESET = 32'h0000_0000;
    localparam logic [31:0] PRDATA_IDLE = 32'h0000_0000;
    // Instruction word fields
    localparam int FAM_MSB = 9;
    localparam int FAM_LSB = 6;
    localparam int BANK_BIT = 5;
    localparam int KIND_BIT = 4;
    localparam int PORT_BIT = 3;
    localparam int IMM_HI_MSB = 8;
    localparam int IMM_HI_LSB = 5;
    localparam logic [3:0] FAM_AND = 4'hd;
    localparam logic [3:0] FAM_OR = 4'he;
    localparam logic [3:0] FAM_XOR = 4'ha;
    localparam logic [3:0] FAM_LOAD = 4'hf;
    localparam logic [3:0] FAM_OUT = 4'h2;
    localparam logic [3:0] FAM_STORE = 4'h3;
    localparam logic [3:0] LO_ROM = 4'h0;
    localparam logic [3:0] LO_IMM = 4'h1;
    localparam logic [3:0] LO_UNARY = 4'h3;
    localparam logic [3:0] POINTER_PAIR = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD = 2'b01,
        ST_RM = 2'b11,
        ST_EX = 2'b10
    } nalu_state_type;

    typedef enum logic [3:0] {
        OP_NOP, OP_REG, OP_ROM, OP_IMM, OP_PORT, OP_INC, OP_ROT, OP_ROTZ,
        OP_OUT_A, OP_OUT_IMM, OP_STORE, OP_PAIR_IMM, OP_PAIR_ROM
    } nalu_op_type;

    typedef struct packed {
        logic [9:0] word2;
        logic [9:0] word1;
    } nalu_instr_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } nalu_apb_req_type;

    typedef struct packed {
        logic [1:0] en;
        logic [3:0] addr;
        logic [7:0] data;
    } nalu_rf_wr_type;
endpackage

/* verilog/nalu_regfile.sv */
// Working register memory: sixteen bank-1/bank-0 nibble pairs
`timescale 1ns/1ps
module nalu_regfile (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] rd_addr,
    input wire nalu_pkg::nalu_rf_wr_type wr,
    output logic [7:0] rd_data,
    output logic [7:0] ptr_data
);
    typedef struct packed {
        logic [15:0][7:0] mem;
        logic [7:0] rd;
        logic [7:0] ptr;
    } nalu_rf_state_type;

    nalu_rf_state_type s_q;
    nalu_rf_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.rd = s_q.mem[rd_addr];
        s_d.ptr = s_q.mem[nalu_pkg::POINTER_PAIR];
        if (wr.en[1]) begin
            s_d.mem[wr.addr][7:4] = wr.data[7:4];
        end
        if (wr.en[0]) begin
            s_d.mem[wr.addr][3:0] = wr.data[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd;
    assign ptr_data = s_q.ptr;
endmodule
